// ==== src/tfw_pkg.sv ====
// constants, types and register map of the disk track format writer
package tfw_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ        = 20_000_000;
	localparam int SEQ_TIMEOUT_S = 40;
	localparam int SEQ_CYCLES    = SEQ_TIMEOUT_S * CLK_HZ;
	localparam int IDX_CYCLES    = 1_000_000;
	localparam int DSL_CYCLES    = 16;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_TGT  = 12'h004;
	localparam logic [11:0] REG_LIM  = 12'h008;
	localparam logic [11:0] REG_SVC  = 12'h00C;
	localparam logic [11:0] REG_PAT  = 12'h010;
	localparam logic [11:0] REG_LEN  = 12'h014;
	localparam logic [11:0] REG_RECS = 12'h018;
	localparam logic [11:0] REG_STAT = 12'h01C;
	localparam logic [11:0] REG_AMM  = 12'h020;
	localparam logic [11:0] REG_RHDR = 12'h024;
	localparam logic [11:0] REG_RDAT = 12'h028;
	// ----------------------------------------
	// field lengths in bytes, index is drive class A,B,C (3 reads as C)
	// ----------------------------------------
	localparam logic [7:0] PRE_SEC [4] = '{8'h24, 8'h30, 8'h1B, 8'h1B};
	localparam logic [7:0] RLK_LEN [4] = '{8'h0A, 8'h0F, 8'h0C, 8'h0C};
	localparam logic [7:0] PAD_SEC [4] = '{8'h0E, 8'h15, 8'h09, 8'h09};
	localparam logic [7:0] LEAD_AM [4] = '{8'h16, 8'h22, 8'h10, 8'h10};
	localparam logic [7:0] VFO_AM  [4] = '{8'h05, 8'h08, 8'h10, 8'h10};
	localparam logic [7:0] PAD_AM  [4] = '{8'h1B, 8'h1C, 8'h10, 8'h10};
	localparam logic [7:0] MARK_LEN = 8'h03;
	localparam logic [7:0] HDR_LEN  = 8'h03;
	localparam logic [7:0] MIN_DATA = 8'h02;
	localparam logic [1:0] CLS_BAD  = 2'h3;
	// ----------------------------------------
	// error codes
	// ----------------------------------------
	localparam logic [7:0] E_ILL  = 8'h00;
	localparam logic [7:0] E_RNG  = 8'h02;
	localparam logic [7:0] E_SEEK = 8'h03;
	localparam logic [7:0] E_AMS  = 8'h05;
	localparam logic [7:0] E_DLEN = 8'h06;
	localparam logic [7:0] E_SVC  = 8'h07;
	localparam logic [7:0] E_AMC  = 8'h09;
	localparam logic [7:0] E_RD   = 8'h14;
	localparam logic [7:0] E_IDX  = 8'h16;
	localparam logic [7:0] E_SEQ  = 8'h18;
	localparam logic [7:0] E_DSL  = 8'h28;
	localparam logic [7:0] E_HALT = 8'h29;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		CMD_NOP, CMD_FORMAT, CMD_WRITE, CMD_READ,
		CMD_SEEK, CMD_SEQUP, CMD_DESEL, CMD_AMCOUNT
	} tfw_cmd_t;
	typedef struct packed {
		logic [22:0] rsv;
		logic        rpt;
		logic        ovr;
		logic [1:0]  cls;
		logic        am;
		tfw_cmd_t    cmd;
		logic        start;
	} tfw_ctrl_t;
	typedef struct packed {
		logic [7:0] rsv;
		logic [7:0] rd_stat;
		logic [3:0] rsv2;
		logic       dat_mis;
		logic       hdr_mis;
		logic       busy;
		logic       err;
		logic [7:0] code;
	} tfw_stat_t;
	typedef struct packed {
		logic       index;
		logic       seek_done;
		logic       seek_inc;
		logic       ready;
		logic       sel_ind;
		logic       wr_sense;
		logic       am_found;
		logic       rd_err;
		logic       rd_bit;
		logic [7:0] rd_stat;
	} tfw_drv_in_t;
	typedef struct packed {
		logic        wr_gate;
		logic        wr_bit;
		logic        am_nt;
		logic        seek_stb;
		logic        seq_req;
		logic        select;
		logic [15:0] cyl;
		logic [7:0]  head;
	} tfw_drv_out_t;
endpackage

// ==== src/tfw_top.sv ====
// track format writer: apb registers, checks and serial field sequencer
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module tfw_top import tfw_pkg::*; #(
	parameter int SEQ_CYC = SEQ_CYCLES,
	parameter int IDX_CYC = IDX_CYCLES,
	parameter int DSL_CYC = DSL_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire tfw_drv_in_t drv_i,
	output tfw_drv_out_t     drv_o
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_CHK, ST_IDX, ST_LEAD, ST_MARK, ST_PRE, ST_HDR,
		ST_RLK, ST_DATA, ST_PAD, ST_HALT, ST_SEEK, ST_SEQ, ST_DESEL,
		ST_AMIDX, ST_AMCNT
	} tfw_state_t;

	tfw_ctrl_t    ctrl;
	tfw_state_t   state, next_state;
	tfw_drv_out_t next_o;
	tfw_stat_t    stat;
	logic [15:0]  tgt_cyl, lim_cyl, svc_lo, dlen, rlen, recs;
	logic [7:0]   tgt_head, lim_head, rd_stat, err_code, next_code;
	logic [31:0]  pattern, rsh, next_rsh, rd_dat, timer, next_timer;
	logic [15:0]  rd_cyl, byte_cnt, fld_len, ovh, rec_left, am_cnt, am_meas;
	logic [7:0]   rd_head, hdr_byte, pat_byte;
	logic [2:0]   bit_cnt;
	logic         err, set_err, hdr_mis, dat_mis, idx_prev, select;
	logic         chk_bad, fld_last, is_fld, bit_val, gate_on;
	logic [7:0]   chk_code;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	wire       setup  = psel & ~penable;
	wire       wr_en  = psel & penable & pwrite;
	wire       hit    = paddr <= REG_RDAT && paddr[1:0] == 2'h0;
	wire       go     = wr_en && paddr == REG_CTRL && pwdata[0] && state == ST_IDLE;
	wire       busy   = state != ST_IDLE;
	wire       idx_rise = drv_i.index & ~idx_prev;
	wire       trk_cmd  = ctrl.cmd inside {CMD_FORMAT, CMD_WRITE, CMD_READ};
	wire       rd_cmd   = ctrl.cmd == CMD_READ;
	wire [1:0] c      = ctrl.cls;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// status word assembled from live state
	always_comb begin
		stat         = '0;
		stat.code    = err_code;
		stat.err     = err;
		stat.busy    = busy;
		stat.hdr_mis = hdr_mis;
		stat.dat_mis = dat_mis;
		stat.rd_stat = rd_stat;
	end

	// read data captured in setup so it stands through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (setup && !pwrite) begin
			case (paddr)
				REG_CTRL: prdata <= ctrl;
				REG_TGT:  prdata <= {8'h00, tgt_head, tgt_cyl};
				REG_LIM:  prdata <= {8'h00, lim_head, lim_cyl};
				REG_SVC:  prdata <= {16'h0000, svc_lo};
				REG_PAT:  prdata <= pattern;
				REG_LEN:  prdata <= {rlen, dlen};
				REG_RECS: prdata <= {16'h0000, recs};
				REG_STAT: prdata <= stat;
				REG_AMM:  prdata <= {16'h0000, am_meas};
				REG_RHDR: prdata <= {8'h00, rd_head, rd_cyl};
				REG_RDAT: prdata <= rd_dat;
				default:  prdata <= '0;
			endcase
		end
	end

	// configuration registers; start bit is not stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl     <= '0;
			{tgt_head, tgt_cyl} <= '0;
			{lim_head, lim_cyl} <= '1;
			svc_lo   <= '1;
			pattern  <= '0;
			{rlen, dlen} <= '0;
			recs     <= '0;
		end else if (wr_en && !busy) begin
			case (paddr)
				REG_CTRL: ctrl <= tfw_ctrl_t'({pwdata[31:1], 1'b0});
				REG_TGT:  {tgt_head, tgt_cyl} <= pwdata[23:0];
				REG_LIM:  {lim_head, lim_cyl} <= pwdata[23:0];
				REG_SVC:  svc_lo <= pwdata[15:0];
				REG_PAT:  pattern <= pwdata;
				REG_LEN:  {rlen, dlen} <= pwdata;
				REG_RECS: recs <= pwdata[15:0];
				default:  ;
			endcase
		end
	end

	// ----------------------------------------
	// command checks
	// ----------------------------------------
	// fixed bytes of one record for the selected mode and class
	assign ovh = ctrl.am ?
		16'(MARK_LEN) + 16'(VFO_AM[c]) + 16'(HDR_LEN) + 16'(RLK_LEN[c]) + 16'(PAD_AM[c]) :
		16'(PRE_SEC[c]) + 16'(HDR_LEN) + 16'(RLK_LEN[c]) + 16'(PAD_SEC[c]);
	wire e_ill = ctrl.cmd == CMD_NOP || c == CLS_BAD;
	wire e_rng = tgt_cyl > lim_cyl || tgt_head > lim_head;
	wire e_ams = trk_cmd && (rlen < ovh + 16'(MIN_DATA) || dlen < 16'(MIN_DATA));
	wire e_dln = trk_cmd && dlen > rlen - ovh;
	wire e_svc = trk_cmd && !ctrl.ovr && tgt_cyl < svc_lo;
	wire e_rng_used = e_rng && (trk_cmd || ctrl.cmd == CMD_SEEK);

	// priority order of refusal codes
	always_comb begin
		chk_bad  = 1'b1;
		chk_code = E_ILL;
		if (e_ill) begin
			chk_code = E_ILL;
		end else if (e_rng_used) begin
			chk_code = E_RNG;
		end else if (e_ams) begin
			chk_code = E_AMS;
		end else if (e_dln) begin
			chk_code = E_DLEN;
		end else if (e_svc) begin
			chk_code = E_SVC;
		end else begin
			chk_bad = 1'b0;
		end
	end

	// ----------------------------------------
	// field sequencer
	// ----------------------------------------
	assign is_fld = state inside {ST_LEAD, ST_MARK, ST_PRE, ST_HDR, ST_RLK, ST_DATA, ST_PAD};

	// length of the current field in bytes
	always_comb begin
		case (state)
			ST_LEAD: fld_len = 16'(LEAD_AM[c]);
			ST_MARK: fld_len = 16'(MARK_LEN);
			ST_PRE:  fld_len = ctrl.am ? 16'(VFO_AM[c]) : 16'(PRE_SEC[c]);
			ST_HDR:  fld_len = 16'(HDR_LEN);
			ST_RLK:  fld_len = 16'(RLK_LEN[c]);
			ST_DATA: fld_len = dlen;
			ST_PAD:  fld_len = ctrl.am ? 16'(PAD_AM[c]) : 16'(PAD_SEC[c]);
			default: fld_len = 16'h0001;
		endcase
	end
	assign fld_last = is_fld && bit_cnt == 3'h7 && byte_cnt == fld_len - 16'h0001;

	// header bytes are binary cylinder high, cylinder low, head
	assign hdr_byte = byte_cnt == 16'h0000 ? tgt_cyl[15:8] :
		byte_cnt == 16'h0001 ? tgt_cyl[7:0] : tgt_head;
	assign pat_byte = pattern[{~byte_cnt[1:0], 3'h0} +: 8];

	// serial bit, msb first; sync one bit closes preamble and relock
	always_comb begin
		case (state)
			ST_PRE, ST_RLK: bit_val = fld_last;
			ST_HDR:         bit_val = hdr_byte[~bit_cnt];
			ST_DATA:        bit_val = pat_byte[~bit_cnt];
			default:        bit_val = 1'b0;
		endcase
	end

	// format writes every field, write from relock on, read never
	always_comb begin
		case (ctrl.cmd)
			CMD_FORMAT: gate_on = 1'b1;
			CMD_WRITE:  gate_on = state inside {ST_RLK, ST_DATA, ST_PAD};
			default:    gate_on = 1'b0;
		endcase
	end
	wire samp = state inside {ST_HDR, ST_DATA} && ctrl.cmd != CMD_FORMAT;
	assign next_rsh = {rsh[30:0], drv_i.rd_bit};

	// ----------------------------------------
	// main control
	// ----------------------------------------
	wire tmo_idx = timer == 32'(IDX_CYC - 1);
	wire tmo_seq = timer == 32'(SEQ_CYC - 1);
	wire tmo_dsl = timer == 32'(DSL_CYC - 1);
	wire rd_fail = is_fld && rd_cmd && drv_i.rd_err;
	tfw_state_t err_dest;
	assign err_dest = ctrl.rpt ? ST_HALT : ST_IDLE;

	always_comb begin
		next_state = state;
		set_err    = 1'b0;
		next_code  = E_ILL;
		case (state)
			ST_IDLE: if (go) begin
				next_state = ST_CHK;
			end
			ST_CHK: if (chk_bad) begin
				set_err    = 1'b1;
				next_code  = chk_code;
				next_state = ST_IDLE;
			end else begin
				case (ctrl.cmd)
					CMD_SEEK:    next_state = ST_SEEK;
					CMD_SEQUP:   next_state = ST_SEQ;
					CMD_DESEL:   next_state = ST_DESEL;
					CMD_AMCOUNT: next_state = ST_AMIDX;
					default:     next_state = ST_IDX;
				endcase
			end
			ST_IDX, ST_AMIDX: if (idx_rise) begin
				if (state == ST_AMIDX) next_state = ST_AMCNT;
				else next_state = ctrl.am ? ST_LEAD : ST_PRE;
			end else if (tmo_idx) begin
				set_err    = 1'b1;
				next_code  = E_IDX;
				next_state = err_dest;
			end
			ST_LEAD: if (fld_last) next_state = ST_MARK;
			ST_MARK: if (fld_last) next_state = ST_PRE;
			ST_PRE:  if (fld_last) next_state = ST_HDR;
			ST_HDR:  if (fld_last) next_state = ST_RLK;
			ST_RLK:  if (fld_last) next_state = ST_DATA;
			ST_DATA: if (fld_last) next_state = ST_PAD;
			ST_PAD:  if (fld_last) begin
				if (rec_left > 16'h0001) next_state = ctrl.am ? ST_MARK : ST_PRE;
				else next_state = ctrl.rpt ? ST_IDX : ST_IDLE;
			end
			ST_HALT: if (!drv_i.wr_sense) begin
				next_state = ST_IDLE;
			end else if (tmo_dsl) begin
				set_err    = 1'b1;
				next_code  = E_HALT;
				next_state = ST_IDLE;
			end
			ST_SEEK: if (drv_i.seek_inc || tmo_idx) begin
				set_err    = 1'b1;
				next_code  = E_SEEK;
				next_state = ST_IDLE;
			end else if (drv_i.seek_done) begin
				next_state = ST_IDLE;
			end
			ST_SEQ: if (drv_i.ready) begin
				next_state = ST_IDLE;
			end else if (tmo_seq) begin
				set_err    = 1'b1;
				next_code  = E_SEQ;
				next_state = ST_IDLE;
			end
			ST_DESEL: if (tmo_dsl) begin
				set_err    = drv_i.sel_ind;
				next_code  = E_DSL;
				next_state = ST_IDLE;
			end
			ST_AMCNT: if (idx_rise) begin
				set_err    = am_cnt != recs;
				next_code  = E_AMC;
				next_state = ST_IDLE;
			end else if (tmo_idx) begin
				set_err    = 1'b1;
				next_code  = E_IDX;
				next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
		if (rd_fail) begin
			set_err    = 1'b1;
			next_code  = E_RD;
			next_state = err_dest;
		end
	end
	assign next_timer = next_state != state ? '0 : timer + 32'h0000_0001;

	// drive outputs: no field is driven once an error is latched
	always_comb begin
		next_o          = drv_o;
		next_o.cyl      = tgt_cyl;
		next_o.head     = tgt_head;
		next_o.select   = select;
		next_o.wr_gate  = !set_err && gate_on && is_fld;
		next_o.wr_bit   = next_o.wr_gate && bit_val;
		next_o.am_nt    = next_o.wr_gate && state == ST_MARK;
		next_o.seek_stb = state == ST_CHK && next_state == ST_SEEK;
		next_o.seq_req  = next_state == ST_SEQ;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			timer <= '0;
			drv_o <= '0;
			idx_prev <= 1'b0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			drv_o <= next_o;
			idx_prev <= drv_i.index;
		end
	end

	// byte and bit counters restart with every field
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{byte_cnt, bit_cnt} <= '0;
		end else if (!is_fld || next_state != state || fld_last) begin
			{byte_cnt, bit_cnt} <= '0;
		end else begin
			{byte_cnt, bit_cnt} <= {byte_cnt, bit_cnt} + 19'h00001;
		end
	end

	// records left on the track, reloaded from recs in ST_CHK and ST_IDX
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rec_left <= '0;
		end else if (state inside {ST_CHK, ST_IDX}) begin
			rec_left <= recs;
		end else if (state == ST_PAD && fld_last) begin
			rec_left <= rec_left - 16'h0001;
		end
	end

	// error latch: set wins, cleared only when a command is started from idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err      <= 1'b0;
			err_code <= E_ILL;
		end else if (set_err) begin
			err      <= 1'b1;
			err_code <= next_code;
		end else if (go) begin
			err      <= 1'b0;
			err_code <= E_ILL;
		end
	end

	// select follows deselect and any other accepted command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			select <= 1'b0;
		end else if (state == ST_CHK && !chk_bad) begin
			select <= ctrl.cmd != CMD_DESEL;
		end
	end

	// address mark counter and measured count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			am_cnt  <= '0;
			am_meas <= '0;
		end else if (state == ST_AMIDX) begin
			am_cnt <= '0;
		end else if (state == ST_AMCNT) begin
			if (idx_rise) am_meas <= am_cnt;
			else if (drv_i.am_found) am_cnt <= am_cnt + 16'h0001;
		end
	end

	// read-back capture and comparison of header and data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsh <= '0;
			{rd_cyl, rd_head, rd_dat, rd_stat} <= '0;
			{hdr_mis, dat_mis} <= '0;
		end else if (go) begin
			{hdr_mis, dat_mis} <= '0;
		end else begin
			if (samp) rsh <= next_rsh;
			if (samp && fld_last && state == ST_HDR) begin
				{rd_cyl, rd_head} <= next_rsh[23:0];
				hdr_mis <= next_rsh[23:0] != {tgt_cyl, tgt_head};
			end
			if (samp && bit_cnt == 3'h7 && state == ST_DATA) begin
				rd_dat <= next_rsh;
				if (next_rsh[7:0] != pat_byte && rd_cmd) dat_mis <= 1'b1;
			end
			if (rd_fail) rd_stat <= drv_i.rd_stat;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence pre_end_s;
		state == ST_PRE && fld_last && gate_on;
	endsequence
	sequence hdr_end_s;
		state == ST_HDR && fld_last && !set_err;
	endsequence
	sync_bit_a: assert property (pre_end_s |=> drv_o.wr_bit)
		else $error("sync bit missing at end of preamble");
	pre_len_a: assert property (state == ST_PRE && fld_last && !ctrl.am
		|-> byte_cnt == 16'(PRE_SEC[c]) - 16'h0001)
		else $error("sector preamble length wrong");
	order_hdr_a: assert property (hdr_end_s |=> state == ST_RLK)
		else $error("relock does not follow header");
	pad_len_a: assert property (state == ST_PAD && fld_last && ctrl.am
		|-> byte_cnt == 16'(PAD_AM[c]) - 16'h0001)
		else $error("address mark pad length wrong");
	lead_first_a: assert property (state == ST_LEAD |-> $past(state) inside {ST_IDX, ST_LEAD})
		else $error("lead zeros outside first record");
	err_hold_a: assert property (err && !go && !set_err |=> err && $stable(err_code))
		else $error("error code lost without new command");
	no_gate_a: assert property (err |-> !drv_o.wr_gate)
		else $error("field driven after error");
	seek_err_a: assert property (state == ST_SEEK && drv_i.seek_inc
		|=> err && err_code == E_SEEK && state == ST_IDLE)
		else $error("seek incomplete not reported");
	seq_tmo_a: assert property (state == ST_SEQ && !drv_i.ready && tmo_seq
		|=> err_code == E_SEQ)
		else $error("sequence timeout not reported");
	am_cnt_a: assert property (state == ST_AMCNT && idx_rise && am_cnt != recs
		|=> err_code == E_AMC && am_meas == $past(am_cnt))
		else $error("address mark mismatch not reported");
endmodule

// ==== sim/tfw_drive.sv ====
// behavioural disk drive at the far side of the track format writer
`timescale 1ns/100ps
module tfw_drive import tfw_pkg::*; (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire tfw_drv_out_t drv_o,
	input  wire logic        bad,
	input  wire logic        idx_en,
	output tfw_drv_in_t      drv_i
);
	int         icnt;
	logic [1:0] scnt;
	logic       track [1500] = '{default: 1'b0};
	// index every 1500 clocks, seek settles after 3, bad drive misbehaves
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			icnt <= 0;
			scnt <= 2'h0;
			drv_i <= '0;
		end else begin
			icnt <= (icnt == 1499) ? 0 : icnt + 1;
			scnt <= drv_o.seek_stb ? 2'h3 : (scnt != 2'h0 ? scnt - 2'h1 : 2'h0);
			drv_i.index <= idx_en && icnt < 2;
			drv_i.seek_done <= !bad && scnt == 2'h1;
			drv_i.seek_inc <= bad && scnt == 2'h1;
			drv_i.ready <= !bad && (drv_i.ready || drv_o.seq_req);
			drv_i.sel_ind <= drv_o.select || bad;
			drv_i.wr_sense <= drv_o.wr_gate || bad;
			drv_i.am_found <= idx_en && icnt % 300 == 150;
			drv_i.rd_err <= bad;
			drv_i.rd_stat <= bad ? 8'hC3 : 8'h00;
			drv_i.rd_bit <= track[(icnt + 2) % 1500]; // offset matches the write path delay
		end
	end
	// track image: written bits kept by rotation position and replayed on read
	always_ff @(posedge pclk) begin
		if (drv_o.wr_gate) track[icnt] <= drv_o.wr_bit;
	end
endmodule

// ==== sim/tb.sv ====
// self-checking testbench of the track format writer
`timescale 1ns/100ps
module tb import tfw_pkg::*;;
	logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic         bad = 0, idx_en = 0, pready, pslverr;
	logic [11:0]  paddr = 0;
	logic [31:0]  pwdata = 0, prdata;
	tfw_drv_in_t  drv_i;
	tfw_drv_out_t drv_o;
	int           miscompares = 0, n_tests = 0, amc;
	logic         wq[$], e[$];
	// ----------------------------------------
	// clock, monitors, instances
	// ----------------------------------------
	always #25 pclk = ~pclk;
	// collect the written stream and address mark cycles
	always @(posedge pclk) begin
		if (drv_o.wr_gate === 1'b1) wq.push_back(drv_o.wr_bit);
		if (drv_o.am_nt === 1'b1) amc++;
	end
	tfw_top #(.SEQ_CYC(200), .IDX_CYC(2000), .DSL_CYC(4)) tfw_top_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .drv_i(drv_i), .drv_o(drv_o));
	tfw_drive tfw_drive_i (.pclk(pclk), .presetn(presetn), .drv_o(drv_o),
		.bad(bad), .idx_en(idx_en), .drv_i(drv_i));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// one apb transfer: setup, then access until pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic se);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (pready !== 1'b1) miscompares++; // no answer within the bus limit
		r = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic s;
		apb(1, a, d, r, s);
	endtask
	// start a command and poll status until busy drops
	task run(input logic [31:0] c, output logic [31:0] st);
		int n;
		logic s;
		wr(REG_CTRL, c);
		repeat (3) @(posedge pclk);
		n = 0;
		st = '1;
		while (st[9] !== 1'b0 && n < 4000) begin
			apb(0, REG_STAT, 0, st, s);
			n++;
		end
		if (st[9] !== 1'b0) miscompares++; // command never finished
	endtask
	function logic [31:0] ctl(tfw_cmd_t c, logic am, logic [1:0] cl, logic ov);
		return {23'h0, 1'b0, ov, cl, am, c, 1'b1};
	endfunction
	task fld(input logic [7:0] n, input logic sy);
		for (int i = 0; i < int'(n) * 8; i++) e.push_back(sy && i == int'(n) * 8 - 1);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		logic [31:0] r;
		logic s;
		apb(0, REG_LIM, 0, r, s);
		check("lim", {8'h0, r[23:0]}, 32'h00FFFFFF);
		apb(0, REG_SVC, 0, r, s);
		check("svc", {16'h0, r[15:0]}, 32'h0000FFFF);
		apb(0, REG_STAT, 0, r, s);
		check("stat", r, 32'h0);
		apb(0, 12'h030, 0, r, s);
		check("unmapped err", {31'h0, s}, 32'h1);
		check("unmapped data", r, 32'h0);
		wr(REG_LIM, 32'h00030010); // cyl max 0x10, head max 3
		$display("test reset done");
	endtask
	task t_fmt(input logic am, input logic [1:0] cl);
		int ov, nb;
		logic [31:0] st;
		ov = am ? MARK_LEN + VFO_AM[cl] + HDR_LEN + RLK_LEN[cl] + PAD_AM[cl]
			: PRE_SEC[cl] + HDR_LEN + RLK_LEN[cl] + PAD_SEC[cl];
		wr(REG_TGT, 32'h00030010); // boundary cylinder and head
		wr(REG_SVC, 32'h0);
		wr(REG_PAT, 32'hA5A5A5A5);
		wr(REG_LEN, 32'((ov + 4) << 16 | 4)); // data fills the record exactly
		wr(REG_RECS, 32'h1);
		wq.delete();
		e.delete();
		amc = 0;
		if (am) begin
			fld(LEAD_AM[cl], 0);
			fld(MARK_LEN, 0);
			fld(VFO_AM[cl], 1);
		end else fld(PRE_SEC[cl], 1);
		for (int i = 23; i >= 0; i--) e.push_back(1'(24'h001003 >> i));
		fld(RLK_LEN[cl], 1);
		for (int i = 31; i >= 0; i--) e.push_back(1'(32'hA5A5A5A5 >> i));
		fld(am ? PAD_AM[cl] : PAD_SEC[cl], 0);
		run(ctl(CMD_FORMAT, am, cl, 0), st);
		nb = 0;
		for (int i = 0; i < e.size(); i++) if (i >= wq.size() || wq[i] !== e[i]) nb++;
		check("fmt status", {22'h0, st[9:0]}, 32'h0);
		check("fmt bit count", wq.size(), e.size());
		check("fmt stream", nb, 0);
		check("mark cycles", amc, am ? 24 : 0);
		$display("test format am %0d class %0d done", am, cl);
	endtask
	task t_err(input logic [31:0] c, input logic [31:0] tgt, input logic [31:0] svc,
		input logic [31:0] len, input logic [7:0] code);
		logic [31:0] st;
		wr(REG_TGT, tgt);
		wr(REG_SVC, svc);
		wr(REG_LEN, len);
		run(c, st);
		check("error status", {22'h0, st[9:0]}, {22'h0, 2'b01, code});
		$display("test error %h done", code);
	endtask
	// write over the last format, then read back header and data
	task t_rw;
		logic [31:0] st, r;
		logic s;
		int nb;
		wr(REG_PAT, 32'h3C3C3C3C);
		wq.delete();
		e.delete();
		fld(RLK_LEN[2], 1);
		for (int i = 31; i >= 0; i--) e.push_back(1'(32'h3C3C3C3C >> i));
		fld(PAD_AM[2], 0);
		run(ctl(CMD_WRITE, 1, 2, 0), st);
		nb = 0;
		for (int i = 0; i < e.size(); i++) if (i >= wq.size() || wq[i] !== e[i]) nb++;
		check("wr status", {20'h0, st[11:0]}, 32'h0);
		check("wr bit count", wq.size(), e.size());
		check("wr stream", nb, 0);
		run(ctl(CMD_READ, 1, 2, 0), st);
		check("rd status", {20'h0, st[11:0]}, 32'h0);
		apb(0, REG_RHDR, 0, r, s);
		check("rd header", r, 32'h00030010);
		apb(0, REG_RDAT, 0, r, s);
		check("rd data", r, 32'h3C3C3C3C);
		wr(REG_PAT, 32'hA5A5A5A5);
		run(ctl(CMD_READ, 1, 2, 0), st);
		check("rd compare", {20'h0, st[11:0]}, 32'h00000800);
		$display("test write and read done");
	endtask
	// the drive gives five address marks per revolution
	task t_am;
		logic [31:0] r, st;
		logic s;
		wr(REG_RECS, 32'h5);
		run(ctl(CMD_AMCOUNT, 0, 0, 0), st);
		check("am status", {22'h0, st[9:0]}, 32'h0);
		wr(REG_RECS, 32'h4);
		run(ctl(CMD_AMCOUNT, 0, 0, 0), st);
		check("am error", {22'h0, st[9:0]}, {24'h1, E_AMC});
		apb(0, REG_AMM, 0, r, s);
		check("am measured", r, 32'h5);
		$display("test address mark count done");
	endtask
	// command that a healthy drive completes without error
	task t_ok(input logic [31:0] c);
		logic [31:0] st;
		run(c, st);
		check("ok status", {22'h0, st[9:0]}, 32'h0);
		$display("test command %h done", c);
	endtask
	// read error once plain, once repeating with the drive still writing
	task t_rderr;
		logic [31:0] r;
		logic s;
		idx_en <= 1;
		t_err(ctl(CMD_READ, 0, 0, 1), 0, 0, 32'h00460004, E_RD);
		apb(0, REG_STAT, 0, r, s);
		check("read status", {24'h0, r[23:16]}, 32'h000000C3);
		t_err(ctl(CMD_READ, 0, 0, 1) | 32'h100, 0, 0, 32'h00460004, E_HALT);
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		idx_en <= 1;
		t_reset;
		for (int a = 0; a < 2; a++) for (int c = 0; c < 3; c++) t_fmt(a[0], c[1:0]);
		t_rw;
		t_am;
		t_err(ctl(CMD_FORMAT, 0, 3, 0), 0, 0, 32'h00460004, E_ILL);
		t_err(ctl(CMD_FORMAT, 0, 0, 0), 32'h00040000, 0, 32'h00460004, E_RNG);
		t_err(ctl(CMD_SEEK, 0, 0, 0), 32'h00000011, 0, 32'h00460004, E_RNG);
		t_err(ctl(CMD_FORMAT, 0, 0, 0), 0, 0, 32'h00460001, E_AMS);
		t_err(ctl(CMD_FORMAT, 0, 0, 0), 0, 0, 32'h00460008, E_DLEN);
		for (int k = 1; k < 4; k++) t_err(ctl(tfw_cmd_t'(k), 0, 0, 0), 4, 5, 32'h00460004, E_SVC);
		t_ok(ctl(CMD_SEEK, 0, 0, 0));
		t_ok(ctl(CMD_SEQUP, 0, 0, 0));
		t_ok(ctl(CMD_DESEL, 0, 0, 0));
		idx_en <= 0;
		t_err(ctl(CMD_FORMAT, 0, 0, 1), 0, 0, 32'h00460004, E_IDX);
		bad <= 1;
		t_err(ctl(CMD_SEEK, 0, 0, 0), 0, 0, 32'h00460004, E_SEEK);
		t_err(ctl(CMD_SEQUP, 0, 0, 0), 0, 0, 32'h00460004, E_SEQ);
		t_err(ctl(CMD_DESEL, 0, 0, 0), 0, 0, 32'h00460004, E_DSL);
		t_rderr;
		conclude;
	end
	initial begin
		repeat (100000) @(posedge pclk);
		miscompares++;
		conclude;
	end
endmodule
